// File: src/sync_alarm_and_mode_status.sv
// sync alarm interrupt byte and read-only operating status register
// assumes a simple register port: addr, wr_en, wdata, rd_data on clk
// Operation
// - sync alarm sets bit 7, write one clears
// - interrupt byte is bits 23:16, reset 0x10
// - status bit 7 shows live sync alarm
// - status register read-only, reset 0x01
`timescale 1ns/100ps
module sync_alarm_and_mode_status (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [6:0] addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rd_data,
  // monitor and loop status
  input  wire logic       sync_alarm_pin,
  input  wire logic       loop_two_locked,
  input  wire logic       loop_one_freq_warning,
  input  wire logic       loop_two_freq_warning,
  input  wire logic [2:0] loop_one_state
);
  logic       alarm_s;
  logic       alarm_prev_q, alarm_prev_d;
  logic [7:0] irq_q, irq_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] rd_d;

  // monitor alarm comes from another domain
  sync_level_sync u_alarm_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (sync_alarm_pin),
    .dout (alarm_s)
  );

  // interrupt byte: set on alarm rising edge beats a same-cycle clear
  always_comb begin
    irq_d        = irq_q;
    alarm_prev_d = alarm_s;
    if (wr_en && addr == sync_status_pkg::off_irq_top_byte) begin
      if (wdata[sync_status_pkg::sync_irq_bit])
        irq_d[sync_status_pkg::sync_irq_bit] = 1'b0;
      // bits 6:0 untouched by writes, keep their reset value 0x10
      irq_d[6:0] = irq_q[6:0];
    end
    if (alarm_s && !alarm_prev_q)
      irq_d[sync_status_pkg::sync_irq_bit] = 1'b1;
  end

  // status snapshot; reads never alter it
  always_comb begin
    mode_d = {alarm_s, loop_two_locked, loop_one_freq_warning,
              loop_two_freq_warning, 1'b0, loop_one_state};
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    if (addr == sync_status_pkg::off_irq_top_byte) begin
      rd_d = irq_q;
    end else if (addr == sync_status_pkg::off_mode_status) begin
      rd_d = mode_q;
    end else begin
      rd_d = 8'h00;
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q        <= sync_status_pkg::irq_top_reset;
      mode_q       <= sync_status_pkg::mode_reset;
      alarm_prev_q <= 1'b0;
      rd_data      <= 8'h00;
    end else begin
      irq_q        <= irq_d;
      mode_q       <= mode_d;
      alarm_prev_q <= alarm_prev_d;
      rd_data      <= rd_d;
    end
  end

  // checks
  property p_flag_set;
    @(posedge clk) disable iff (rst) (alarm_s && !alarm_prev_q) |=> irq_q[7];
  endproperty
  flag_set_a: assert property (p_flag_set) else $error("alarm edge not latched");
  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == sync_status_pkg::off_irq_top_byte && wdata[7] && !(alarm_s && !alarm_prev_q))
    |=> !irq_q[7]) else $error("write one did not clear");
  flag_hold_a: assert property (@(posedge clk) disable iff (rst)
    (irq_q[7] && !(wr_en && addr == sync_status_pkg::off_irq_top_byte && wdata[7]))
    |=> irq_q[7]) else $error("flag lost without clear");
  low_bits_a: assert property (@(posedge clk) disable iff (rst)
    ##1 irq_q[6:0] == 7'h10) else $error("unused bits changed");
  irq_read_a: assert property (@(posedge clk) disable iff (rst)
    addr == sync_status_pkg::off_irq_top_byte |=> rd_data == $past(irq_q))
    else $error("interrupt read wrong");
  live_alarm_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> mode_q[7] == $past(alarm_s)) else $error("live alarm wrong");
  mode_read_a: assert property (@(posedge clk) disable iff (rst)
    addr == sync_status_pkg::off_mode_status |=> rd_data == $past(mode_q))
    else $error("status read wrong");
  mode_bit3_a: assert property (@(posedge clk) disable iff (rst)
    !mode_q[3]) else $error("status bit 3 set");

  // shorthand terms for the checks below; they only feed assertions
  logic irq_wr_s;
  logic alarm_rise_s;
  logic mapped_s;
  assign irq_wr_s     = wr_en && (addr == sync_status_pkg::off_irq_top_byte);
  assign alarm_rise_s = alarm_s && !alarm_prev_q;
  assign mapped_s     = (addr == sync_status_pkg::off_irq_top_byte) ||
                        (addr == sync_status_pkg::off_mode_status);

  // a write that asks for the flag to be cleared
  sequence s_clear_write;
    irq_wr_s && wdata[sync_status_pkg::sync_irq_bit];
  endsequence

  // a clear with no alarm edge racing it
  sequence s_clean_clear;
    irq_wr_s && wdata[sync_status_pkg::sync_irq_bit] && !alarm_rise_s;
  endsequence

  // a write of zero to the flag bit
  sequence s_zero_write;
    irq_wr_s && !wdata[sync_status_pkg::sync_irq_bit];
  endsequence

  // a read of the interrupt byte
  sequence s_irq_read;
    addr == sync_status_pkg::off_irq_top_byte;
  endsequence

  // clean clear followed at once by a read of the same byte
  sequence s_clear_then_read;
    s_clean_clear ##1 s_irq_read;
  endsequence

  // alarm edge coinciding with a clear; losing it would hide an alarm
  sequence s_set_and_clear;
    alarm_rise_s && irq_wr_s && wdata[sync_status_pkg::sync_irq_bit];
  endsequence

  // set beats a clear in the same cycle
  property p_set_wins;
    @(posedge clk) disable iff (rst)
      s_set_and_clear |=> irq_q[sync_status_pkg::sync_irq_bit];
  endproperty
  set_wins_a: assert property (p_set_wins)
    else $error("clear beat alarm edge");

  // read back after a clear shows the flag low
  property p_clear_read;
    @(posedge clk) disable iff (rst)
      s_clear_then_read |=> !rd_data[sync_status_pkg::sync_irq_bit];
  endproperty
  clear_read_a: assert property (p_clear_read)
    else $error("cleared flag read high");

  // zero written to a set flag leaves it set
  property p_zero_keeps;
    @(posedge clk) disable iff (rst)
      (s_zero_write and irq_q[sync_status_pkg::sync_irq_bit])
      |=> irq_q[sync_status_pkg::sync_irq_bit];
  endproperty
  zero_keeps_a: assert property (p_zero_keeps)
    else $error("zero write cleared flag");

  // a clear write ends with the flag low unless an edge raced it
  property p_clear_seq;
    @(posedge clk) disable iff (rst)
      s_clear_write |=> (irq_q[sync_status_pkg::sync_irq_bit] == $past(alarm_rise_s));
  endproperty
  clear_seq_a: assert property (p_clear_seq)
    else $error("clear result wrong");

  // loop fields follow their inputs one cycle late
  property p_mode_fields;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (mode_q[sync_status_pkg::lock_two_bit] == $past(loop_two_locked)) &&
               (mode_q[sync_status_pkg::warn_one_bit] == $past(loop_one_freq_warning)) &&
               (mode_q[sync_status_pkg::warn_two_bit] == $past(loop_two_freq_warning)) &&
               (mode_q[2:0] == $past(loop_one_state));
  endproperty
  mode_fields_a: assert property (p_mode_fields)
    else $error("status fields wrong");

  // unmapped addresses read back zero
  property p_unmapped_zero;
    @(posedge clk) disable iff (rst)
      !mapped_s |=> rd_data == 8'h00;
  endproperty
  unmapped_zero_a: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  // first edge after reset: both registers still at their reset pattern
  property p_reset_values;
    @(posedge clk)
      $fell(rst) |-> (irq_q == sync_status_pkg::irq_top_reset) &&
                     (mode_q == sync_status_pkg::mode_reset) &&
                     (rd_data == 8'h00);
  endproperty
  reset_values_a: assert property (p_reset_values)
    else $error("reset values wrong");
endmodule // sync_alarm_and_mode_status

// File: src/sync_level_sync.sv
// three-stage synchroniser for one external level
// assumes the input is asynchronous to clk
`timescale 1ns/100ps
module sync_level_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and out
  input  wire logic din,
  output logic      dout
);
  logic s1_q, s2_q, s3_q, s1_d, s2_d, s3_d, out_d;
  // next values; change taken once stages two and three agree
  always_comb begin
    s1_d  = din;
    s2_d  = s1_q;
    s3_d  = s2_q;
    out_d = (s2_q == s3_q) ? s3_q : dout;
  end
  // stage registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      dout <= out_d;
    end
  end
endmodule // sync_level_sync

// File: src/sync_status_pkg.sv
// constants for the sync alarm and operating status registers
// assumes an 8-bit register port shared with the rest of the device
package sync_status_pkg;
  localparam logic [6:0] off_mode_status  = 7'h09; // operating status register
  localparam logic [6:0] off_irq_top_byte = 7'h08; // interrupt bits 23:16
  localparam logic [7:0] irq_top_reset    = 8'h10;
  localparam logic [7:0] mode_reset       = 8'h01;
  localparam int         sync_irq_bit     = 7;
  localparam int         sync_live_bit    = 7;
  localparam int         lock_two_bit     = 6;
  localparam int         warn_one_bit     = 5;
  localparam int         warn_two_bit     = 4;
  localparam logic [2:0] state_reset      = 3'h1;
endpackage

// File: verif/tb_top.sv
// bench for the sync alarm byte and the operating status register
// assumes the design and its package are compiled first
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, pin = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rd_data;
  logic lock2 = 1'b0, warn1 = 1'b0, warn2 = 1'b0;
  logic [2:0] st = 3'h1;
  int fails = 0, n_checks = 0, cyc = 0;
  int flag = 0; // model of the sticky alarm flag
  sync_alarm_and_mode_status i_dut (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
    .wdata(wdata), .rd_data(rd_data), .sync_alarm_pin(pin), .loop_two_locked(lock2),
    .loop_one_freq_warning(warn1), .loop_two_freq_warning(warn2), .loop_one_state(st));
  always #5 clk = ~clk;
  // hang guard, far above the roughly 110 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  // read data is registered, so it is looked at one edge later
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    addr = a;
    @(negedge clk);
    chk(rd_data, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    addr = a; wdata = d; wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    // one idle edge so back-to-back writes never retoggle the strobe
    @(negedge clk);
  endtask
  function automatic logic [7:0] stat();
    return {pin, lock2, warn1, warn2, 1'b0, st};
  endfunction
  task print_verdict();
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hb4888dc0));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(7'h08, 8'h10);
    rd(7'h09, 8'h01);
    // alarm through the synchroniser, flag and live bit both set
    pin = 1'b1;
    repeat (8) @(negedge clk);
    flag = 1;
    rd(7'h08, 8'h10 | (flag << 7));
    rd(7'h09, stat());
    wr(7'h08, 8'h00);
    wr(7'h08, 8'h7f);
    rd(7'h08, 8'h90);
    wr(7'h08, 8'h80);
    flag = 0;
    rd(7'h08, 8'h10 | (flag << 7));
    pin = 1'b0;
    repeat (8) @(negedge clk);
    rd(7'h09, stat());
    // alarm edge lands on the clear strobe: the set must win
    pin = 1'b1;
    repeat (4) @(negedge clk);
    wr(7'h08, 8'h80);
    rd(7'h08, 8'h90);
    // reset in mid-run, pin still high
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(7'h09, 8'h01);
    rd(7'h08, 8'h10);
    repeat (8) @(negedge clk);
    rd(7'h08, 8'h90);
    // random status inputs and ignored writes to the status register
    for (int i = 0; i < 20; i++) begin
      {lock2, warn1, warn2, st} = 6'($urandom());
      wr(7'h09, 8'($urandom()));
      rd(7'h09, stat());
    end
    rd(7'h0a, 8'h00);
    print_verdict();
  end
endmodule // tb_top
